/* logic/ppcf_pad_config.v */
// pad configuration registers and input conditioning for two pins
// assumes divider enables are one-cycle pulses on i_clk_sys and pins are synchronous
// Contract
// - pull field bits 4:3 selects none, pull-down, pull-up or bus keeper.
// - polarity bit 6 inverts the pin level seen by the read path.
// - bit 10 makes output drive only low; high is released, emulated.
// - filter mode 0 at bits 12:11 bypasses the filter; resets to 0.
// - filter modes 1..3 need the change held for 1..3 sampling clocks.
// - bits 15:13 pick one of seven divider enables; reset picks divider 0.
//
// Our own choice: strobed register access.
`include "ppcf_defines.vh"
module ppcf_pad_config (
    input  wire        i_clk_sys,
    input  wire        i_srst,
    input  wire [31:0] i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    input  wire [3:0]  i_boot_pull,
    input  wire [6:0]  i_div_en,
    input  wire [1:0]  i_pin_in,
    input  wire [1:0]  i_out_data,
    input  wire [1:0]  i_out_en,
    output wire [1:0]  o_pin_out,
    output wire [1:0]  o_pin_oe,
    output wire [1:0]  o_pin_level,
    output wire [1:0]  o_pull_down,
    output wire [1:0]  o_pull_up,
    output wire [1:0]  o_keeper,
    output wire [1:0]  o_schmitt_enable
);
    reg  [1:0]  pull_reg [0:1];
    reg  [1:0]  schmitt_reg;
    reg  [1:0]  flip_reg;
    reg  [1:0]  drain_reg;
    reg  [1:0]  fmode_reg [0:1];
    reg  [2:0]  fdiv_reg  [0:1];
    reg         boot_load_reg;
    reg  [31:0] rdata_next;
    wire [1:0]  hit;
    wire [1:0]  filt_out;

    assign hit[0] = (i_addr == `PPCF_ADDR_P0_31);
    assign hit[1] = (i_addr == `PPCF_ADDR_P1_0);

    // boot pull values are caught one edge after reset release, never in reset itself
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            boot_load_reg <= 1'h1;
        end else begin
            boot_load_reg <= 1'h0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_pin
            wire [1:0] pull_sel;
            wire       sample_en;

            // register fields; a write in the boot load cycle loses to the boot value
            always @(posedge i_clk_sys) begin
                if (i_srst) begin
                    pull_reg[g]    <= `PPCF_PULL_NONE;
                    schmitt_reg[g] <= `PPCF_SCHMITT_RST;
                    flip_reg[g]    <= 1'h0;
                    drain_reg[g]   <= 1'h0;
                    fmode_reg[g]   <= `PPCF_FMODE_RST;
                    fdiv_reg[g]    <= `PPCF_FDIV_RST;
                end else if (boot_load_reg) begin
                    pull_reg[g] <= i_boot_pull[2*g+1:2*g];
                end else if (i_wr && hit[g]) begin
                    pull_reg[g]    <= i_wdata[`PPCF_PULL_MSB:`PPCF_PULL_LSB];
                    schmitt_reg[g] <= i_wdata[`PPCF_SCHMITT_BIT];
                    flip_reg[g]    <= i_wdata[`PPCF_FLIP_BIT];
                    drain_reg[g]   <= i_wdata[`PPCF_DRAIN_BIT];
                    fmode_reg[g]   <= i_wdata[`PPCF_FMODE_MSB:`PPCF_FMODE_LSB];
                    fdiv_reg[g]    <= i_wdata[`PPCF_FDIV_MSB:`PPCF_FDIV_LSB];
                end
            end

            // pull decode to the pad controls
            assign pull_sel       = pull_reg[g];
            assign o_pull_down[g] = (pull_sel == `PPCF_PULL_DOWN);
            assign o_pull_up[g]   = (pull_sel == `PPCF_PULL_UP);
            assign o_keeper[g]    = (pull_sel == `PPCF_PULL_KEEP);
            assign o_schmitt_enable[g] = schmitt_reg[g];

            // value 7 has no source; it selects nothing so the filter simply holds
            assign sample_en = (fdiv_reg[g] == `PPCF_FDIV_BAD) ? 1'h0
                             : i_div_en[fdiv_reg[g]];

            ppcf_glitch_filter u_filt (
                .i_clk_sys   (i_clk_sys),
                .i_srst      (i_srst),
                .i_pin       (i_pin_in[g]),
                .i_mode      (fmode_reg[g]),
                .i_sample_en (sample_en),
                .o_level     (filt_out[g])
            );

            // polarity applies after the filter on the read path
            assign o_pin_level[g] = filt_out[g] ^ flip_reg[g];

            // emulated open drain: drive low only, release for a high
            assign o_pin_out[g] = drain_reg[g] ? 1'h0 : i_out_data[g];
            assign o_pin_oe[g]  = drain_reg[g] ? (i_out_en[g] & ~i_out_data[g])
                                               : i_out_en[g];
        end
    endgenerate

    // read mux; reserved 9:7 always read their fixed pattern, unmapped reads zero
    always @* begin
        rdata_next = 32'h00000000;
        if (hit[0] || hit[1]) begin
            rdata_next[`PPCF_PULL_MSB:`PPCF_PULL_LSB] = hit[0] ? pull_reg[0] : pull_reg[1];
            rdata_next[`PPCF_SCHMITT_BIT] = hit[0] ? schmitt_reg[0] : schmitt_reg[1];
            rdata_next[`PPCF_FLIP_BIT]    = hit[0] ? flip_reg[0] : flip_reg[1];
            rdata_next[`PPCF_RSVD_MSB:`PPCF_RSVD_LSB] = `PPCF_RSVD_VAL;
            rdata_next[`PPCF_DRAIN_BIT]   = hit[0] ? drain_reg[0] : drain_reg[1];
            rdata_next[`PPCF_FMODE_MSB:`PPCF_FMODE_LSB] = hit[0] ? fmode_reg[0] : fmode_reg[1];
            rdata_next[`PPCF_FDIV_MSB:`PPCF_FDIV_LSB]   = hit[0] ? fdiv_reg[0] : fdiv_reg[1];
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            o_rdata <= rdata_next;
        end else begin
            o_rdata <= 32'h00000000;
        end
    end
endmodule

/* logic/ppcf_defines.vh */
// constants for the pad configuration and input filter block
// assumes a 32-bit register port with byte addresses as printed
`ifndef PPCF_DEFINES_VH
`define PPCF_DEFINES_VH
`define PPCF_ADDR_P0_31     32'h4004408C
`define PPCF_ADDR_P1_0      32'h40044090
`define PPCF_PULL_LSB       3
`define PPCF_PULL_MSB       4
`define PPCF_SCHMITT_BIT    5
`define PPCF_FLIP_BIT       6
`define PPCF_RSVD_LSB       7
`define PPCF_RSVD_MSB       9
`define PPCF_DRAIN_BIT      10
`define PPCF_FMODE_LSB      11
`define PPCF_FMODE_MSB      12
`define PPCF_FDIV_LSB       13
`define PPCF_FDIV_MSB       15
`define PPCF_RSVD_VAL       3'h1
`define PPCF_SCHMITT_RST    1'h1
`define PPCF_FMODE_RST      2'h0
`define PPCF_FDIV_RST       3'h0
`define PPCF_PULL_NONE      2'h0
`define PPCF_PULL_DOWN      2'h1
`define PPCF_PULL_UP        2'h2
`define PPCF_PULL_KEEP      2'h3
`define PPCF_FDIV_BAD       3'h7
`define PPCF_NUM_DIV        7
`endif

/* logic/ppcf_glitch_filter.v */
// glitch filter for one pin input, sampled on a divider enable pulse
// assumes the pin input is already synchronous to i_clk_sys
`include "ppcf_defines.vh"
module ppcf_glitch_filter (
    input  wire       i_clk_sys,
    input  wire       i_srst,
    input  wire       i_pin,
    input  wire [1:0] i_mode,
    input  wire       i_sample_en,
    output wire       o_level
);
    reg       filt_reg;
    reg [1:0] cnt_reg;

    // count samples that differ from the held level; a matching sample restarts
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            filt_reg <= 1'h0;
            cnt_reg  <= 2'h0;
        end else if (i_mode == `PPCF_FMODE_RST) begin
            filt_reg <= i_pin; // track so that enabling the filter causes no edge
            cnt_reg  <= 2'h0;
        end else if (i_sample_en) begin
            if (i_pin == filt_reg) begin
                cnt_reg <= 2'h0;
            end else if (cnt_reg + 2'h1 >= i_mode) begin
                filt_reg <= i_pin;
                cnt_reg  <= 2'h0;
            end else begin
                cnt_reg <= cnt_reg + 2'h1;
            end
        end
    end

    // bypass is combinational so mode 0 adds no latency
    assign o_level = (i_mode == `PPCF_FMODE_RST) ? i_pin : filt_reg;
endmodule

/* tb/ppcf_asserts.sv */
// port checks for the pad config block, slot port0_pin31; reserved bits are read at PPCF_ADDR_P1_0
// bound to ppcf_pad_config; reset is high at time zero
`include "ppcf_defines.vh"
module ppcf_asserts (
    input wire        i_clk_sys,
    input wire        i_srst,
    input wire [31:0] i_addr,
    input wire [31:0] i_wdata,
    input wire        i_wr,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire [1:0]  i_pin_in,
    input wire [1:0]  i_out_data,
    input wire [1:0]  o_pin_out,
    input wire [1:0]  o_pin_oe,
    input wire [1:0]  o_pin_level,
    input wire [1:0]  o_pull_up,
    input wire [1:0]  o_keeper,
    input wire [1:0]  o_schmitt_enable
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);
    // a write in the boot-load cycle is lost, so it is left out
    logic        wv;
    logic        sr_d;
    logic [31:0] wd;
    always_ff @(posedge i_clk_sys) begin
        sr_d <= i_srst;
        wv   <= i_wr && i_addr == `PPCF_ADDR_P0_31 && !i_srst && !sr_d;
        wd   <= i_wdata;
    end
    pull_up_a: assert property (wv |-> o_pull_up[0] == (wd[4:3] == 2'h2))
        else $error("pull-up decode");
    keeper_on_a: assert property (wv |-> o_keeper[0] == (wd[4:3] == 2'h3))
        else $error("keeper decode");
    schmitt_bit_a: assert property (wv |-> o_schmitt_enable[0] == wd[5])
        else $error("schmitt bit");
    rsvd_read_a: assert property ($past(i_rd) && $past(i_addr) == `PPCF_ADDR_P1_0
        |-> o_rdata[9:7] == 3'h1 && o_rdata[31:16] == 16'h0) else $error("reserved bits");
    drive_data_a: assert property (o_pin_oe[0] |-> o_pin_out[0] == i_out_data[0])
        else $error("drive data");
    drain_low_a: assert property (wv && wd[10] |-> !(o_pin_oe[0] && o_pin_out[0]))
        else $error("drove high");
    flip_now_a: assert property (wv && wd[12:11] == 2'h0
        |-> o_pin_level[0] == (i_pin_in[0] ^ wd[6])) else $error("flip bypass");
    reset_pass_a: assert property ($past(i_srst) |-> o_pin_level == i_pin_in)
        else $error("reset bypass");
endmodule
bind ppcf_pad_config ppcf_asserts u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin_in(i_pin_in), .i_out_data(i_out_data), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe), .o_pin_level(o_pin_level), .o_pull_up(o_pull_up),
    .o_keeper(o_keeper), .o_schmitt_enable(o_schmitt_enable));

/* tb/ppcf_pad_model.sv */
// pad model for two pins: drive, bench drive, pulls, keeper
// resolves each wire level and feeds it back as pin input
module ppcf_pad_model (
    input  wire logic       i_clk_sys,
    input  wire logic [1:0] i_out,
    input  wire logic [1:0] i_oe,
    input  wire logic [1:0] i_up,
    input  wire logic [1:0] i_down,
    input  wire logic [1:0] i_keep,
    input  wire logic [1:0] i_drv,
    input  wire logic [1:0] i_drv_en,
    output logic      [1:0] o_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] last = 2'h0;
    // a floating wire shows the inverse of its last level, so no stale value
    always_comb begin
        for (int i = 0; i < 2; i++)
            o_level[i] = i_oe[i] ? i_out[i] : i_drv_en[i] ? i_drv[i] :
                i_up[i] ? 1'b1 : i_down[i] ? 1'b0 : i_keep[i] ? last[i] : !last[i];
    end
    always_ff @(posedge i_clk_sys) last <= o_level;
endmodule

/* tb/tb.sv */
// self-checking bench for the pad config block
// stands alone; the pad model closes the pin loop
`include "ppcf_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, e;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d, rnd = 32'h5304FB20, q[$];
    logic [6:0]  den = 7'h0;
    logic [1:0]  drv = 2'h0, drv_en = 2'h2, od = 2'h0, oe = 2'h0;
    logic [1:0]  pin, po, poe, lvl, pd, pu, kp, se;
    int          n_fail = 0, n_checks = 0, cyc = 0;
    initial forever #10 clk = ~clk;
    ppcf_pad_config DUT (.i_clk_sys(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_boot_pull(4'h9), .i_div_en(den),
        .i_pin_in(pin), .i_out_data(od), .i_out_en(oe), .o_pin_out(po), .o_pin_oe(poe),
        .o_pin_level(lvl), .o_pull_down(pd), .o_pull_up(pu), .o_keeper(kp),
        .o_schmitt_enable(se));
    ppcf_pad_model pad (.i_clk_sys(clk), .i_out(po), .i_oe(poe), .i_up(pu), .i_down(pd),
        .i_keep(kp), .i_drv(drv), .i_drv_en(drv_en), .o_level(pin));
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic w(logic [31:0] a, logic [31:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic r(logic [31:0] a, logic [31:0] x);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        q.push_back(x);
        @(posedge clk);
        rd   <= 1'b0;
    endtask
    // one divider pulse, then look once the edge has landed
    task automatic pulse(int k);
        @(posedge clk);
        den <= 7'(1 << k);
        @(posedge clk);
        den <= 7'h0;
        @(negedge clk);
    endtask
    // read data is matched in issue order; also cuts a hang short
    always @(posedge clk) begin
        if (rd_d)
            chk("rdata", q.pop_front(), rdata);
        rd_d <= rd;
        cyc++;
        if (cyc > 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        r(`PPCF_ADDR_P0_31, 32'h000000A8);
        r(`PPCF_ADDR_P1_0, 32'h000000B0);
        for (int i = 0; i < 4; i++) begin
            d = (xs() & 32'h000007E0) | (i << 3) | ((i + 3) << 13);
            w(`PPCF_ADDR_P0_31, d);
            r(`PPCF_ADDR_P0_31, (d & 32'h0000FC78) | 32'h00000080);
            chk("pull_down", i == 1, pd[0]);
        end
        w(32'h40044094, xs());
        r(32'h40044094, 32'h0);
        w(`PPCF_ADDR_P1_0, 32'h00000040);
        repeat (4) begin
            d = xs();
            @(posedge clk);
            drv <= d[1:0];
            @(negedge clk);
            chk("flip", !drv[1], lvl[1]);
        end
        w(`PPCF_ADDR_P0_31, 32'h00000400);
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            od <= 2'(v);
            oe <= 2'h1;
            @(negedge clk);
            chk("pin_oe", v == 0, poe[0]);
        end
        w(`PPCF_ADDR_P0_31, 32'h0);
        // the drain bit clears at the edge the write returns on; look once it has settled
        @(negedge clk);
        chk("pin_oe", 1'b1, poe[0]);
        @(posedge clk);
        oe     <= 2'h0;
        drv_en <= 2'h3;
        drv    <= 2'h0;
        e = 1'b0;
        for (int m = 1; m < 4; m++) begin
            w(`PPCF_ADDR_P0_31, (m << 11) | 32'h00006000);
            @(posedge clk);
            drv <= {drv[1], !e};
            repeat (m) pulse(2);
            repeat (m - 1) pulse(3);
            chk("filt_hold", e, lvl[0]);
            pulse(3);
            chk("filt_pass", !e, lvl[0]);
            e = !e;
        end
        report_and_stop();
    end
endmodule
